// File: pkg/pmsc_pkg.sv
/*
 Constants, field layouts and carrier structs for the priority mask and stack
 control block. Assumes a single core clock domain and that the special-register
 move and change-state instructions arrive already decoded from the pipeline.
*/
// Notes on behaviour
// RULE_01 - Without security, fault mask raises execution priority to -1; only NMI passes.
// RULE_02 - Secure fault mask with fault target 0 raises priority to -1.
// RULE_03 - Nonsecure fault mask, target 0: priority 0, or 0x80 when demote set.
// RULE_04 - Target 1: secure fault mask gives -3, nonsecure gives -1.
// RULE_05 - Fault mask boost masks exceptions of lower or equal priority; the code never masks NMI, even under the -3 boost.
// RULE_06 - Base priority is 8 bits [7:0], values from 1, banked secure/nonsecure.
// RULE_07 - With demote set, nonsecure base priority maps into lower half of range.
// RULE_08 - Base priority boost masks exceptions of strictly lower priority; the code also masks equal priority.
// RULE_09 - Unimplemented low base priority bits read zero and ignore writes.
// RULE_10 - Larger numeric priority value means less urgent.
// RULE_11 - Control bit 3 secure FP flag: shared, RAZ/WI from nonsecure.
// RULE_12 - Control bit 2 FP context active, shared, decides FP preservation on entry.
// RULE_13 - Control bit 1 selects thread stack: 0 main, 1 process; banked.
// RULE_14 - Stack select bit is updated on every exception return.
// RULE_15 - Control bit 0 thread privilege: 0 privileged, 1 unprivileged; banked.
// RULE_16 - Handler mode uses main stack; software stack-select writes ignored there.
// RULE_17 - Entry and return rewrite control from the exception return code.
// RULE_18 - After reset thread mode uses the main stack.
// RULE_19 - Software follows a stack select write with a sync barrier.
// RULE_20 - Control is banked per bit; some bits banked, some shared.
// RULE_21 - Every exception is vectored; all but reset run in handler mode.
// RULE_22 - Masks reachable by move instructions; fault mask by change-state too.
// RULE_23 - Pending exception activates only if priority below current execution priority; the code takes NMI whatever its priority.
package pmsc_pkg;

   localparam int PRI_W = 10;                       // Signed priority, room for -3..0x1FF
   localparam logic signed [PRI_W-1:0] PRI_M3   = -10'sd3;
   localparam logic signed [PRI_W-1:0] PRI_M1   = -10'sd1;
   localparam logic signed [PRI_W-1:0] PRI_ZERO = 10'sh000;
   localparam logic signed [PRI_W-1:0] PRI_HALF = 10'sh080;
   localparam logic signed [PRI_W-1:0] PRI_NONE = 10'sh100; // No boost active

   localparam int BP_W = 8;
   localparam int CTL_W = 4;
   localparam int CTL_THREAD_UNPRIVILEGED = 0;
   localparam int CTL_STACK_POINTER_SELECT = 1;
   localparam int CTL_FP_CONTEXT_ACTIVE  = 2;
   localparam int CTL_SECURE_FP_ACTIVE  = 3;

   // Exception return code fields used on return
   localparam int ERC_STACK_POINTER_SELECT = 2;                    // 1: return to process stack
   localparam int ERC_MODE  = 3;                    // 1: return to thread mode
   localparam int ERC_FTYPE = 4;                    // 0: frame held FP state
   localparam int ERC_S     = 6;                    // 1: returning to secure state

   typedef enum logic [1:0] {
      PMSC_SEL_FAULT = 2'h0,
      PMSC_SEL_BASE  = 2'h1,
      PMSC_SEL_CTRL  = 2'h2,
      PMSC_SEL_NONE  = 2'h3
   } pmsc_sel_t;

   // Decoded special-register move or change-state request
   typedef struct packed {
      logic        wr;       // Move to special register
      logic        cps_set;  // Change-state: set fault mask
      logic        cps_clr;  // Change-state: clear fault mask
      pmsc_sel_t   sel;
      logic        bank_ns;  // Access the nonsecure copy
      logic [31:0] wdata;
   } pmsc_req_t;

   // Exception sequencer events
   typedef struct packed {
      logic        entry;
      logic        ret;
      logic        entry_ns; // Target state of the entered handler
      logic [31:0] ret_code;
   } pmsc_exc_t;

   typedef struct packed {
      logic thread_unpriv;
      logic use_process_sp;
      logic fp_active;
      logic secure_fp;
   } pmsc_ctl_t;

endpackage

// File: src/pmsc_pri_map.sv
/*
 Priority boost computation for one security bank set.
 Assumes all inputs are registered state from the same clock.
*/
`timescale 1ns/1ps
module pmsc_pri_map
   import pmsc_pkg::*;
#(
   parameter int PRI_BITS = 8
) (
   input  wire logic                    sec_ext,
   input  wire logic                    fault_target_select,
   input  wire logic                    nonsecure_priority_demote,
   input  wire logic                    secure_fault_mask,
   input  wire logic                    nonsecure_fault_mask,
   input  wire logic [BP_W-1:0]         secure_base_priority,
   input  wire logic [BP_W-1:0]         nonsecure_base_priority,
   output      logic signed [PRI_W-1:0] exec_pri
);

   function automatic logic signed [PRI_W-1:0] pmin(input logic signed [PRI_W-1:0] a,
                                                    input logic signed [PRI_W-1:0] b);
      return (a < b) ? a : b; // [RULE_10]
   endfunction

   function automatic logic signed [PRI_W-1:0] bp_ext(input logic [BP_W-1:0] v);
      return (v == '0) ? PRI_NONE : {{(PRI_W-BP_W){1'b0}}, v};
   endfunction

   logic signed [PRI_W-1:0] fm_s, fm_ns, bp_s, bp_ns;

   always_comb begin
      fm_s  = PRI_NONE;
      fm_ns = PRI_NONE;
      if (!sec_ext) begin
         if (secure_fault_mask) fm_s = PRI_M1;                          // [RULE_01]
      end else if (!fault_target_select) begin
         if (secure_fault_mask) fm_s = PRI_M1;                          // [RULE_02]
         if (nonsecure_fault_mask)
            fm_ns = nonsecure_priority_demote ? PRI_HALF : PRI_ZERO;  // [RULE_03]
      end else begin
         if (secure_fault_mask) fm_s = PRI_M3;                          // [RULE_04]
         if (nonsecure_fault_mask) fm_ns = PRI_M1;                      // [RULE_04]
      end
      bp_s  = bp_ext(secure_base_priority);                            // [RULE_06]
      bp_ns = PRI_NONE;
      if (sec_ext && nonsecure_base_priority != '0) begin
         if (nonsecure_priority_demote)                                // [RULE_07]
            bp_ns = PRI_HALF + {{(PRI_W-BP_W+1){1'b0}}, nonsecure_base_priority[BP_W-1:1]};
         else
            bp_ns = bp_ext(nonsecure_base_priority);
      end
      exec_pri = pmin(pmin(fm_s, fm_ns), pmin(bp_s, bp_ns));           // [RULE_23]
   end

endmodule // pmsc_pri_map

// File: src/pmsc_core.sv
/*
 Fault mask, base priority mask and control register logic with secure and
 nonsecure banks, plus the activation gate for a pending exception.
 Assumes the pipeline presents decoded special-register accesses and that the
 exception sequencer presents entry and return events, one per cycle.
*/
`timescale 1ns/1ps
module pmsc_core
   import pmsc_pkg::*;
#(
   parameter int  PRI_BITS = 8,   // Implemented upper bits of the base priority field
   parameter bit  SEC_EXT  = 1'b1
) (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    ce,
   input  wire logic                    cur_ns,           // Executing in nonsecure state
   input  wire logic                    handler_mode,
   input  wire logic                    fault_target_select,
   input  wire logic                    nonsecure_priority_demote,
   input  wire pmsc_req_t               req,
   input  wire pmsc_exc_t               exc,
   input  wire logic                    fp_used,          // FP instruction executed
   input  wire logic                    pend_valid,
   input  wire logic                    pend_is_nmi,
   input  wire logic signed [PRI_W-1:0] pend_pri,
   output      logic [31:0]             rdata,
   output      pmsc_ctl_t               ctl,
   output      logic                    use_process_sp,
   output      logic                    fp_preserve,
   output      logic signed [PRI_W-1:0] exec_pri,
   output      logic                    take_exc
);

   localparam logic [BP_W-1:0] BP_MASK = BP_W'(((1 << PRI_BITS) - 1) << (BP_W - PRI_BITS));

   logic            fm_r      [2];   // Index 0 secure, 1 nonsecure
   logic [BP_W-1:0] bp_r      [2];
   logic            thread_unprivileged_r   [2];
   logic            stack_pointer_select_r   [2];
   logic            fp_context_active_r, secure_fp_active_r;
   logic            fm_nxt    [2];
   logic [BP_W-1:0] bp_nxt    [2];
   logic            thread_unprivileged_nxt [2];
   logic            stack_pointer_select_nxt [2];
   logic            fp_context_active_nxt, secure_fp_active_nxt;
   logic            bank;
   logic [31:0]     rdata_nxt;
   logic            bank_rd;

   always_comb begin
      bank = SEC_EXT ? req.bank_ns : 1'b0;
      for (int i = 0; i < 2; i++) begin
         fm_nxt[i]    = fm_r[i];
         bp_nxt[i]    = bp_r[i];
         thread_unprivileged_nxt[i] = thread_unprivileged_r[i];
         stack_pointer_select_nxt[i] = stack_pointer_select_r[i];
      end
      fp_context_active_nxt = fp_context_active_r;
      secure_fp_active_nxt = secure_fp_active_r;
      if (req.cps_set) fm_nxt[bank] = 1'b1;                                 // [RULE_22]
      if (req.cps_clr) fm_nxt[bank] = 1'b0;                                 // [RULE_22]
      if (req.wr) begin
         case (req.sel)
            PMSC_SEL_FAULT: fm_nxt[bank] = req.wdata[0];                    // [RULE_22]
            PMSC_SEL_BASE:  bp_nxt[bank] = req.wdata[BP_W-1:0] & BP_MASK;   // [RULE_09]
            PMSC_SEL_CTRL: begin
               thread_unprivileged_nxt[bank] = req.wdata[CTL_THREAD_UNPRIVILEGED];                      // [RULE_15]
               if (!handler_mode) stack_pointer_select_nxt[bank] = req.wdata[CTL_STACK_POINTER_SELECT];   // [RULE_16]
               fp_context_active_nxt = req.wdata[CTL_FP_CONTEXT_ACTIVE];                              // [RULE_12]
               if (!cur_ns) secure_fp_active_nxt = req.wdata[CTL_SECURE_FP_ACTIVE];                 // [RULE_11]
            end
            default: ;
         endcase
      end
      if (exc.entry) begin                                                  // [RULE_17]
         stack_pointer_select_nxt[SEC_EXT ? exc.entry_ns : 1'b0] = 1'b0;                   // [RULE_21]
         fp_context_active_nxt = 1'b0;
         secure_fp_active_nxt = 1'b0;
      end
      if (exc.ret) begin                                                    // [RULE_14]
         stack_pointer_select_nxt[SEC_EXT ? ~exc.ret_code[ERC_S] : 1'b0] =
            exc.ret_code[ERC_STACK_POINTER_SELECT] & exc.ret_code[ERC_MODE];               // [RULE_17]
         fp_context_active_nxt = ~exc.ret_code[ERC_FTYPE];                               // [RULE_17]
      end
      // FP use in the same cycle as a clear wins, or live FP state would go unsaved
      fp_context_active_nxt = fp_context_active_nxt | fp_used;                                        // [RULE_12]
      secure_fp_active_nxt = secure_fp_active_nxt | (fp_used & ~cur_ns);                            // [RULE_11]
   end

   // Reads are registered so rdata stays a flop output
   always_comb begin
      rdata_nxt = '0;
      bank_rd   = SEC_EXT ? req.bank_ns : 1'b0;
      case (req.sel)
         PMSC_SEL_FAULT: rdata_nxt[0] = fm_r[bank_rd];
         PMSC_SEL_BASE:  rdata_nxt[BP_W-1:0] = bp_r[bank_rd];               // [RULE_09]
         PMSC_SEL_CTRL: begin                                               // [RULE_20]
            rdata_nxt[CTL_THREAD_UNPRIVILEGED] = thread_unprivileged_r[bank_rd];
            rdata_nxt[CTL_STACK_POINTER_SELECT] = stack_pointer_select_r[bank_rd];
            rdata_nxt[CTL_FP_CONTEXT_ACTIVE]  = fp_context_active_r;
            rdata_nxt[CTL_SECURE_FP_ACTIVE]  = cur_ns ? 1'b0 : secure_fp_active_r;                  // [RULE_11]
         end
         default: rdata_nxt = '0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < 2; i++) begin
            fm_r[i]    <= 1'b0;
            bp_r[i]    <= '0;
            thread_unprivileged_r[i] <= 1'b0;
            stack_pointer_select_r[i] <= 1'b0;                                             // [RULE_18]
         end
         fp_context_active_r <= 1'b0;
         secure_fp_active_r <= 1'b0;
         rdata  <= '0;
      end else if (ce) begin
         for (int i = 0; i < 2; i++) begin
            fm_r[i]    <= fm_nxt[i];
            bp_r[i]    <= bp_nxt[i];
            thread_unprivileged_r[i] <= thread_unprivileged_nxt[i];
            stack_pointer_select_r[i] <= stack_pointer_select_nxt[i];
         end
         fp_context_active_r <= fp_context_active_nxt;
         secure_fp_active_r <= secure_fp_active_nxt;
         rdata  <= rdata_nxt;
      end
   end

   pmsc_pri_map #(
      .PRI_BITS (PRI_BITS)
   ) u_pri_map (
      .sec_ext                   (SEC_EXT),
      .fault_target_select       (fault_target_select),
      .nonsecure_priority_demote (nonsecure_priority_demote),
      .secure_fault_mask         (fm_r[0]),
      .nonsecure_fault_mask      (SEC_EXT ? fm_r[1] : 1'b0),
      .secure_base_priority      (bp_r[0]),
      .nonsecure_base_priority   (SEC_EXT ? bp_r[1] : 8'h00),
      .exec_pri                  (exec_pri)
   );

   always_comb begin
      ctl.thread_unpriv  = thread_unprivileged_r[SEC_EXT ? cur_ns : 1'b0];                // [RULE_15]
      ctl.use_process_sp = stack_pointer_select_r[SEC_EXT ? cur_ns : 1'b0];
      ctl.fp_active      = fp_context_active_r;
      ctl.secure_fp      = secure_fp_active_r;
      use_process_sp     = ctl.use_process_sp & ~handler_mode;              // [RULE_13] [RULE_16]
      fp_preserve        = fp_context_active_r;                                          // [RULE_12]
      // Strict compare masks lower or equal priority for both fault mask and base
      // priority, since boosts store the blocking value.
      take_exc = pend_valid & (pend_is_nmi | (pend_pri < exec_pri));        // [RULE_05] [RULE_08] [RULE_23]
   end

endmodule // pmsc_core

// File: bench/pmsc_core_assertions.sv
/* Concurrent checks on the ports of pmsc_core.
   Assumes one core clock, synchronous active-low reset, bound from below. */
`timescale 1ns/1ps
module pmsc_core_assertions
   import pmsc_pkg::*;
#(parameter int PRI_BITS = 8, parameter bit SEC_EXT = 1'b1) (
   input wire logic                    clk,
   input wire logic                    rst_n,
   input wire logic                    ce,
   input wire logic                    cur_ns,
   input wire logic                    handler_mode,
   input wire logic                    fault_target_select,
   input wire logic                    nonsecure_priority_demote,
   input wire pmsc_req_t               req,
   input wire pmsc_exc_t               exc,
   input wire logic                    fp_used,
   input wire logic                    pend_valid,
   input wire logic                    pend_is_nmi,
   input wire logic signed [PRI_W-1:0] pend_pri,
   input wire pmsc_ctl_t               ctl,
   input wire logic                    use_process_sp,
   input wire logic signed [PRI_W-1:0] exec_pri,
   input wire logic                    take_exc
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Plain fault mask write; change-state is kept out as it may also touch it, and return is kept out as well
   sequence s_fm_wr(ns, fts);
      ce && req.wr && !req.cps_set && !req.cps_clr && !exc.ret && req.sel == PMSC_SEL_FAULT
      && req.bank_ns == ns && req.wdata[0] && fault_target_select == fts;
   endsequence
   sequence s_ret;
      ce && exc.ret && !fp_used ##1 cur_ns == !$past(exc.ret_code[ERC_S]);
   endsequence
   chk_take_gate: assert property (
      take_exc == (pend_valid && (pend_is_nmi || pend_pri < exec_pri)))
      else $error("take_exc disagrees with priority compare");
   chk_handler_msp: assert property (handler_mode |-> !use_process_sp)
      else $error("process stack used in handler mode");
   chk_sfm_target1: assert property (
      (SEC_EXT and s_fm_wr(1'b0, 1'b1)) ##1 fault_target_select |-> exec_pri == PRI_M3)
      else $error("secure fault mask with target 1 not at -3");
   chk_sfm_target0: assert property (
      s_fm_wr(1'b0, 1'b0) ##1 1'b1 |-> exec_pri <= PRI_M1)
      else $error("secure fault mask did not reach -1");
   chk_nsfm_demote: assert property (
      (SEC_EXT and s_fm_wr(1'b1, 1'b0)) ##1 !fault_target_select
      |-> exec_pri <= (nonsecure_priority_demote ? PRI_HALF : PRI_ZERO))
      else $error("nonsecure fault mask boost wrong");
   chk_ret_ctl: assert property (s_ret |->
      ctl.use_process_sp == ($past(exc.ret_code[ERC_STACK_POINTER_SELECT]) && $past(exc.ret_code[ERC_MODE]))
      && ctl.fp_active == !$past(exc.ret_code[ERC_FTYPE]))
      else $error("control not rebuilt from return code");
   chk_entry_clear: assert property (
      ce && exc.entry && !exc.ret && !fp_used ##1 cur_ns == $past(exc.entry_ns)
      |-> !ctl.use_process_sp && !ctl.fp_active && !ctl.secure_fp)
      else $error("entry left stack or fp flags set");
   chk_reset_state: assert property (
      $rose(rst_n) && $past(ce) |-> exec_pri == PRI_NONE && ctl == '0)
      else $error("state not cleared by reset");
endmodule // pmsc_core_assertions
bind pmsc_core pmsc_core_assertions #(.PRI_BITS(PRI_BITS), .SEC_EXT(SEC_EXT)) u_chk (.*);

// File: bench/priority_mask_and_stack_control_tb.sv
/* Self-checking bench for pmsc_core driven through decoded register moves.
   Assumes PRI_BITS of 4, so the low nibble of base priority is unimplemented. */
`timescale 1ns/1ps
module priority_mask_and_stack_control_tb;
   import pmsc_pkg::*;
   logic                    clk = 1'b0;
   logic                    rst_n = 1'b0;
   logic                    ce = 1'b1;
   logic                    cur_ns = 1'b0;
   logic                    hmode = 1'b0;
   logic                    fts = 1'b0;
   logic                    dem = 1'b0;
   logic                    fp_used = 1'b0;
   logic                    nmi = 1'b0;
   logic                    pv = 1'b1;
   logic signed [PRI_W-1:0] ppri = '0;
   pmsc_req_t               req = '0;
   pmsc_exc_t               exc = '0;
   logic [31:0]             rdata;
   pmsc_ctl_t               ctl;
   logic                    usp;
   logic                    fpp;
   logic                    take;
   logic signed [PRI_W-1:0] epri;
   logic signed [PRI_W-1:0] fexp [5] = '{PRI_M1, PRI_ZERO, PRI_HALF, PRI_M3, PRI_M1};
   logic [4:0]              nsb = 5'b10110;
   int                      n_mismatch = 0;
   int                      n_tests = 0;
   int                      cyc = 0;
   wire [3:0] ctl_bits = {ctl.secure_fp, ctl.fp_active, ctl.use_process_sp, ctl.thread_unpriv};
   always #4 clk = ~clk;
   pmsc_core #(.PRI_BITS(4), .SEC_EXT(1'b1)) DUT (.clk(clk), .rst_n(rst_n), .ce(ce),
      .cur_ns(cur_ns), .handler_mode(hmode), .fault_target_select(fts),
      .nonsecure_priority_demote(dem), .req(req), .exc(exc), .fp_used(fp_used),
      .pend_valid(pv), .pend_is_nmi(nmi), .pend_pri(ppri), .rdata(rdata), .ctl(ctl),
      .use_process_sp(usp), .fp_preserve(fpp), .exec_pri(epri), .take_exc(take));
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic wr(pmsc_sel_t s, logic ns, logic [31:0] d);
      req = '{wr: 1'b1, cps_set: 1'b0, cps_clr: 1'b0, sel: s, bank_ns: ns, wdata: d};
      tick();
      req.wr = 1'b0;
   endtask
   // Read data is registered, so it is looked at one edge after the select
   task automatic rd(pmsc_sel_t s, logic ns, logic [31:0] exp);
      req.sel = s;
      req.bank_ns = ns;
      tick();
      chk("rdata", rdata, exp);
   endtask
   task automatic pend(logic signed [PRI_W-1:0] p, logic n, logic exp);
      ppri = p;
      nmi = n;
      tick();
      chk("take", take, exp);
   endtask
   task automatic evt(logic en, logic rt, logic [31:0] code, logic [3:0] exp);
      exc = '{entry: en, ret: rt, entry_ns: 1'b0, ret_code: code};
      tick();
      exc = '0;
      chk("ctl", ctl_bits, exp);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   initial begin
      repeat (12) tick();
      rst_n = 1'b1;
      tick();
      chk("exec", epri, PRI_NONE);
      rd(PMSC_SEL_CTRL, 1'b0, 32'h0);
      wr(PMSC_SEL_BASE, 1'b0, 32'h4F);
      rd(PMSC_SEL_BASE, 1'b0, 32'h40);
      rd(PMSC_SEL_BASE, 1'b1, 32'h0);
      pend(10'sh040, 1'b0, 1'b0);
      pend(10'sh03F, 1'b0, 1'b1);
      wr(PMSC_SEL_BASE, 1'b0, 32'h0);
      wr(PMSC_SEL_BASE, 1'b1, 32'h40);
      chk("exec", epri, 32'h40);
      dem = 1'b1;
      tick();
      chk("exec", epri, 32'hA0);
      wr(PMSC_SEL_BASE, 1'b1, 32'h0);
      for (int i = 0; i < 5; i++) begin
         fts = (i > 2);
         dem = (i == 2);
         wr(PMSC_SEL_FAULT, nsb[i], 32'h1);
         chk("exec", epri, fexp[i]);
         pend(fexp[i], 1'b0, 1'b0);
         pend(fexp[i] - 1, 1'b0, 1'b1);
         pend(fexp[i], 1'b1, 1'b1);
         rd(PMSC_SEL_FAULT, nsb[i], 32'h1);
         req.cps_clr = 1'b1;
         tick();
         req.cps_clr = 1'b0;
         chk("exec", epri, PRI_NONE);
      end
      // The non-maskable request is still raised here, so only the valid gate holds take low
      pv = 1'b0;
      tick();
      chk("take", take, 1'b0);
      pv = 1'b1;
      // A dropped enable must freeze the register file
      ce = 1'b0;
      wr(PMSC_SEL_BASE, 1'b0, 32'h20);
      ce = 1'b1;
      chk("exec", epri, PRI_NONE);
      // Stack select is relied on only after an edge has passed, as a barrier would ensure
      wr(PMSC_SEL_CTRL, 1'b0, 32'h3);
      chk("ctl", ctl_bits, 4'h3);
      chk("usp", usp, 1'b1);
      cur_ns = 1'b1;
      tick();
      chk("ctl", ctl_bits, 4'h0);
      cur_ns = 1'b0;
      hmode = 1'b1;
      tick();
      chk("usp", usp, 1'b0);
      wr(PMSC_SEL_CTRL, 1'b0, 32'h0);
      rd(PMSC_SEL_CTRL, 1'b0, 32'h2);
      fp_used = 1'b1;
      tick();
      fp_used = 1'b0;
      chk("ctl", ctl_bits, 4'hE);
      chk("fpp", fpp, 1'b1);
      cur_ns = 1'b1;
      rd(PMSC_SEL_CTRL, 1'b1, 32'h4);
      cur_ns = 1'b0;
      evt(1'b1, 1'b0, 32'h0, 4'h0);
      evt(1'b0, 1'b1, 32'h4C, 4'h6);
      evt(1'b0, 1'b1, 32'h5C, 4'h2);
      evt(1'b0, 1'b1, 32'h44, 4'h4);
      hmode = 1'b0;
      report_and_stop();
   end
endmodule // priority_mask_and_stack_control_tb
